/* File: kick_model.sv */
// Microcontroller model that sends watchdog kick pulses of a set low length.
// Assumes the bench raises fire for one cycle per pulse.
`timescale 1ns/1ps
`default_nettype none
module kick_model
(
    input wire logic ref_clk,
    input wire logic fire,
    input wire logic [7:0] low_cyc,
    output logic watchdog_kick_n
);
    logic [7:0] cnt = 8'h00;
    initial watchdog_kick_n = 1'b1;
    // Low length is chosen by the bench; 40 cycles keeps a legal kick
    always @(posedge ref_clk)
    begin
        if (cnt != 8'h00)
        begin
            cnt <= cnt - 8'h01;
            watchdog_kick_n <= (cnt == 8'h01);
        end
        else if (fire)
        begin
            cnt <= low_cyc;
            watchdog_kick_n <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// Bench for the window watchdog reset with a kick-sending model.
// Assumes a 4-cycle tick and a 200-cycle reset pulse.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int RST = 200;
    logic ref_clk, nrst, fire;
    logic [7:0] low_cyc;
    logic kick_n, oe, fs, sv, pin_short, pin_open;
    wdog_pkg::mode_in_s mode_in;
    wdog_pkg::source_code_s src;
    logic [4:0] st;
    int mismatches = 0, comparisons = 0, cycles = 0, n;
    wire logic line_n = ~oe;
    kick_model mcu (.ref_clk(ref_clk), .fire(fire), .low_cyc(low_cyc), .watchdog_kick_n(kick_n));
    window_watchdog_reset #(.RESET_TIME_CYC(32'(RST)), .OSC_PERIOD_CYC(16'h0004)) uut (
        .ref_clk(ref_clk), .nrst(nrst), .watchdog_kick_n(kick_n), .timebase_short(pin_short),
        .timebase_open(pin_open), .mode_in(mode_in), .sys_reset_n_in(line_n), .sys_reset_n_out(),
        .sys_reset_n_oe(oe), .fail_safe(fs), .source_valid(sv), .source_code(src), .wd_state(st));
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            mismatches++;
            complete_run;
        end
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    // Tick phase and the kick qualifier blur edges by a few cycles
    task near(input string nm, input int exp, input int got);
        comparisons++;
        if (got < exp - 12 || got > exp + 12)
        begin
            mismatches++;
            $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task wait_st(input logic [4:0] s);
        n = 0;
        while (st !== s && n < 40000)
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task kick(input logic [7:0] len);
        low_cyc = len;
        fire = 1'b1;
        @(negedge ref_clk);
        fire = 1'b0;
    endtask
    task t_powerup;
        wait_st(5'h02);
        near("por_len", RST, n);
        chk("oe_lead", 0, oe);
        $display("powerup done");
    endtask
    task t_lead_kick;
        kick(8'd40);
        wait_st(5'h04);
        near("lead_kick", 29, n);
        repeat (20) @(negedge ref_clk);
        kick(8'd10);
        repeat (60) @(negedge ref_clk);
        chk("glitch_state", 5'h04, st);
        wait_st(5'h08);
        near("closed_len", 1053 * 4 - 81, n);
        $display("lead kick done");
    endtask
    task t_open_then_early;
        kick(8'd40);
        wait_st(5'h04);
        near("open_kick", 29, n);
        repeat (20) @(negedge ref_clk);
        kick(8'd40);
        wait_st(5'h10);
        near("early_kick", 29, n);
        repeat (4) @(negedge ref_clk);
        chk("wd_src", 2'b11, src);
        chk("fail_safe", 1, fs);
        chk("wd_valid", 1, sv);
        wait_st(5'h02);
        near("wd_pulse", RST - 4, n);
        $display("open and early kick done");
    endtask
    task t_open_timeout;
        kick(8'd40);
        wait_st(5'h08);
        wait_st(5'h10);
        near("open_len", 1105 * 4, n);
        wait_st(5'h02);
        $display("open timeout done");
    endtask
    // Receive data falls well after wake, so the lead time must restart there
    task t_lead_timeout;
        repeat (8000) @(negedge ref_clk);
        mode_in.rxd_fall = 1'b0;
        wait_st(5'h10);
        near("lead_len", 7895 * 4, n);
        chk("lead_fs", 1, fs);
        wait_st(5'h02);
        near("lead_pulse", RST, n);
        chk("lead_valid", 1, sv);
        chk("lead_src", 2'b11, src);
        $display("lead timeout done");
    endtask
    task t_low_power;
        mode_in.silent_mode = 1'b1;
        repeat (100) @(negedge ref_clk);
        kick(8'd40);
        repeat (1900) @(negedge ref_clk);
        chk("silent_state", 5'h02, st);
        mode_in.silent_mode = 1'b0;
        mode_in.sleep_mode = 1'b1;
        repeat (40) @(negedge ref_clk);
        chk("sleep_oe", 0, oe);
        chk("sleep_fs", 0, fs);
        chk("sleep_valid", 0, sv);
        mode_in.sleep_mode = 1'b0;
        $display("low power done");
    endtask
    // A 4-cycle tick would leave the closed window after 4212 cycles
    task t_timebase;
        pin_short = 1'b1;
        repeat (4) @(negedge ref_clk);
        kick(8'd40);
        wait_st(5'h04);
        near("fb_kick", 29, n);
        repeat (5000) @(negedge ref_clk);
        chk("short_closed", 5'h04, st);
        pin_short = 1'b0;
        pin_open = 1'b1;
        repeat (5000) @(negedge ref_clk);
        chk("open_closed", 5'h04, st);
        pin_open = 1'b0;
        $display("timebase fallback done");
    endtask
    task t_undervoltage;
        mode_in.vcc_undervoltage = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk("uv_oe", 1, oe);
        chk("uv_src", 2'b10, src);
        mode_in.vcc_undervoltage = 1'b0;
        wait_st(5'h02);
        near("uv_por", RST, n);
        $display("undervoltage done");
    endtask
    initial
    begin
        nrst = 1'b0;
        fire = 1'b0;
        low_cyc = 8'h00;
        mode_in = '0;
        mode_in.rxd_fall = 1'b1;
        pin_short = 1'b0;
        pin_open = 1'b0;
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        t_powerup();
        t_lead_kick();
        t_open_then_early();
        t_open_timeout();
        t_low_power();
        t_lead_timeout();
        t_undervoltage();
        t_timebase();
        complete_run();
    end
endmodule
`default_nettype wire

/* File: wdog_assertions.sv */
// Checker for the window watchdog reset ports.
// Assumes ref_clk and nrst as the only domain.
`timescale 1ns/1ps
`default_nettype none
module wdog_checker
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sys_reset_n_in,
    input wire logic sys_reset_n_out,
    input wire logic sys_reset_n_oe,
    input wire logic fail_safe,
    input wire logic source_valid,
    input wire wdog_pkg::mode_in_s mode_in,
    input wire wdog_pkg::source_code_s source_code,
    input wire logic [4:0] wd_state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    out_low_a: assert property (sys_reset_n_out == 1'b0) else $error("reset pin data not low");
    reset_drive_a: assert property (wd_state == 5'h10 |-> ##[0:2] sys_reset_n_oe)
        else $error("reset state without pull");
    closed_quiet_a: assert property ((wd_state == 5'h04)[*3] |-> !sys_reset_n_oe)
        else $error("pull during closed window");
    fs_set_a: assert property (!sys_reset_n_in |-> ##[0:3] fail_safe)
        else $error("fail-safe not set");
    wd_src_a: assert property (wd_state == 5'h10 |-> ##[0:3] (source_code == 2'b11 && source_valid))
        else $error("watchdog source wrong");
    uv_reset_a: assert property (mode_in.vcc_undervoltage |-> ##[1:6] sys_reset_n_oe)
        else $error("undervoltage without pull");
    uv_src_a: assert property (mode_in.vcc_undervoltage[*8] |-> source_code == 2'b10)
        else $error("undervoltage source wrong");
    low_power_a: assert property ((mode_in.silent_mode || mode_in.sleep_mode)[*8] |-> wd_state == 5'h02)
        else $error("watchdog runs in low power");
    one_hot_a: assert property ($onehot(wd_state)) else $error("state not one-hot");
    closed_entry_a: assert property ($rose(wd_state == 5'h04) |->
        ($past(wd_state) == 5'h02 || $past(wd_state) == 5'h08)) else $error("bad closed entry");
endmodule
bind window_watchdog_reset wdog_checker chk (.ref_clk(ref_clk), .nrst(nrst), .sys_reset_n_in(sys_reset_n_in),
    .sys_reset_n_out(sys_reset_n_out), .sys_reset_n_oe(sys_reset_n_oe), .fail_safe(fail_safe),
    .source_valid(source_valid), .mode_in(mode_in), .source_code(source_code), .wd_state(wd_state));
`default_nettype wire

/* File: wdog_defines.svh */
// Timing constants for the window watchdog reset block.
// Assumes a 125 MHz ref_clk; included by the main module only.
`ifndef WDOG_DEFINES_SVH
`define WDOG_DEFINES_SVH
`define CLK_PERIOD_PS 8000
`define TRIG_MIN_NS 200
// Least time rounds up: 200 ns / 8 ns = 25 cycles
`define TRIG_MIN_CYC ((`TRIG_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define LEAD_TICKS 7895
`define CLOSED_TICKS 1053
`define OPEN_TICKS 1105
`define RESET_TIME_MS 4
// Worked in ns so the intermediate product stays inside a 32-bit int
`define RESET_TIME_CYC_DEF ((`RESET_TIME_MS * 1000000) / (`CLK_PERIOD_PS / 1000))
// Oscillator period default for a 51 kOhm resistor, in ns
`define OSC_PERIOD_NS_DEF 19600
`define OSC_PERIOD_CYC_DEF ((`OSC_PERIOD_NS_DEF * 1000) / `CLK_PERIOD_PS)
// Fallback tick periods for a shorted or open timebase pin (90 ms / 7895, 390 ms / 7895)
`define OSC_SHORT_NS 11400
`define OSC_OPEN_NS 49398
`define OSC_SHORT_CYC ((`OSC_SHORT_NS * 1000) / `CLK_PERIOD_PS)
`define OSC_OPEN_CYC ((`OSC_OPEN_NS * 1000) / `CLK_PERIOD_PS)
`endif

/* File: wdog_pkg.sv */
// Types shared by the window watchdog reset block.
// Constants live in wdog_defines.svh.
`default_nettype none
package wdog_pkg;
    typedef enum logic [4:0] {
        ST_POR    = 5'b00001,
        ST_LEAD   = 5'b00010,
        ST_CLOSED = 5'b00100,
        ST_OPEN   = 5'b01000,
        ST_RESET  = 5'b10000
    } wd_state_e;

    typedef enum logic [1:0] {
        SRC_NONE  = 2'h0,
        SRC_WDOG  = 2'h1,
        SRC_UVOLT = 2'h2
    } reset_src_e;

    typedef struct packed {
        logic silent_mode;
        logic sleep_mode;
        logic rxd_fall;
        logic vcc_undervoltage;
    } mode_in_s;

    typedef struct packed {
        logic txd;
        logic rxd;
    } source_code_s;
endpackage
`default_nettype wire

/* File: wdog_tick_gen.sv */
// Oscillator tick generator: one-cycle pulse every period_cyc ref_clk cycles.
// Period is picked from the resistor pin state by the main module.
`timescale 1ns/1ps
`default_nettype none
module wdog_tick_gen
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [15:0] period_cyc,
    output logic tick
);
    logic [15:0] count;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 16'h0000;
            tick <= 1'b0;
        end
        else if (count + 16'h0001 >= period_cyc)
        begin
            count <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: window_watchdog_reset.sv */
// Window watchdog that drives an open-drain active-low reset to a microcontroller.
// Assumes mode and supply inputs are asynchronous pins; the oscillator is modelled as a tick on ref_clk.
// Summary of operation
// - Kick falling edge triggers; missed window resets.
// - Low pulses under 200 ns are ignored.
// - Intervals counted in oscillator ticks.
// - Trigger period scales 20 to 64 ms.
// - Watchdog off in silent or sleep.
// - Power-up reset held about 4 ms.
// - Lead time is 7895 ticks.
// - Wake starts lead at receive-data fall.
// - Trigger in lead starts closed window.
// - Lead timeout gives fixed 4 ms reset.
// - Closed 1053 ticks, open 1105 ticks.
// - Trigger in closed window resets at once.
// - Trigger in open window restarts closed.
// - Open window timeout gives reset.
// - Shorted pin 90 ms, open 390 ms.
// - Reset guaranteed outside fallback trigger periods.
// - Timing tolerance 20 percent, aim centre.
// - Undervoltage drives reset, enters fail-safe.
// - Any reset low enters fail-safe.
// - Fail-safe reports source on transmit/receive.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defines.svh"
module window_watchdog_reset
#(
    parameter logic [31:0] RESET_TIME_CYC = `RESET_TIME_CYC_DEF,
    parameter logic [15:0] OSC_PERIOD_CYC = 16'(`OSC_PERIOD_CYC_DEF)
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic watchdog_kick_n,
    input wire logic timebase_short,
    input wire logic timebase_open,
    input wire wdog_pkg::mode_in_s mode_in,
    input wire logic sys_reset_n_in,
    output logic sys_reset_n_out,
    output logic sys_reset_n_oe,
    output logic fail_safe,
    output logic source_valid,
    output wdog_pkg::source_code_s source_code,
    output logic [4:0] wd_state
);
    logic [1:0] kick_sync;
    logic [1:0] short_sync;
    logic [1:0] open_sync;
    logic [1:0] silent_sync;
    logic [1:0] sleep_sync;
    logic [1:0] rxd_sync;
    logic [1:0] uv_sync;
    logic [1:0] pin_sync;
    logic rxd_prev;
    logic low_power;
    logic uv;
    logic kick_low;
    logic [7:0] low_count;
    logic qualified;
    logic kick_event;
    logic tick;
    logic [15:0] tick_period;
    logic [12:0] win_count;
    logic [31:0] reset_count;
    logic reset_drive;
    logic uv_seen;
    wdog_pkg::wd_state_e state;
    wdog_pkg::reset_src_e last_src;

    // Two-stage synchronisers for every pin input
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            kick_sync <= 2'h3;
            short_sync <= 2'h0;
            open_sync <= 2'h0;
            silent_sync <= 2'h0;
            sleep_sync <= 2'h0;
            rxd_sync <= 2'h3;
            uv_sync <= 2'h0;
            pin_sync <= 2'h0;
        end
        else
        begin
            kick_sync <= {kick_sync[0], watchdog_kick_n};
            short_sync <= {short_sync[0], timebase_short};
            open_sync <= {open_sync[0], timebase_open};
            silent_sync <= {silent_sync[0], mode_in.silent_mode};
            sleep_sync <= {sleep_sync[0], mode_in.sleep_mode};
            rxd_sync <= {rxd_sync[0], mode_in.rxd_fall};
            uv_sync <= {uv_sync[0], mode_in.vcc_undervoltage};
            pin_sync <= {pin_sync[0], sys_reset_n_in};
        end
    end

    assign low_power = silent_sync[1] | sleep_sync[1];
    assign uv = uv_sync[1];
    assign kick_low = ~kick_sync[1];

    // Fallback periods stand in for a faulty resistor pin
    always_comb
    begin
        if (short_sync[1])
            tick_period = 16'(`OSC_SHORT_CYC);
        else if (open_sync[1])
            tick_period = 16'(`OSC_OPEN_CYC);
        else
            tick_period = OSC_PERIOD_CYC;
    end

    wdog_tick_gen u_tick
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .period_cyc(tick_period),
        .tick(tick)
    );

    // Kick is counted as valid once low for the minimum width; the edge that
    // crossed it stands in for the falling edge, so short glitches never reach the window logic.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            low_count <= 8'h00;
            qualified <= 1'b0;
            kick_event <= 1'b0;
        end
        else
        begin
            kick_event <= 1'b0;
            if (!kick_low)
            begin
                low_count <= 8'h00;
                qualified <= 1'b0;
            end
            else if (!qualified)
            begin
                if (low_count >= 8'(`TRIG_MIN_CYC - 1))
                begin
                    qualified <= 1'b1;
                    kick_event <= 1'b1;
                end
                else
                    low_count <= low_count + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            rxd_prev <= 1'b1;
        else
            rxd_prev <= rxd_sync[1];
    end

    // Window state machine; counters clear on every transition
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= wdog_pkg::ST_POR;
            win_count <= 13'h0000;
            reset_count <= 32'h0000_0000;
        end
        else if (uv)
        begin
            state <= wdog_pkg::ST_POR;
            win_count <= 13'h0000;
            reset_count <= 32'h0000_0000;
        end
        else if (low_power)
        begin
            state <= wdog_pkg::ST_LEAD;
            win_count <= 13'h0000;
            reset_count <= 32'h0000_0000;
        end
        else
        begin
            unique case (state)
                wdog_pkg::ST_POR, wdog_pkg::ST_RESET:
                begin
                    // Reset length is in ref_clk cycles, so it ignores the resistor
                    if (reset_count >= RESET_TIME_CYC - 32'h1)
                    begin
                        state <= wdog_pkg::ST_LEAD;
                        reset_count <= 32'h0000_0000;
                        win_count <= 13'h0000;
                    end
                    else
                        reset_count <= reset_count + 32'h1;
                end
                wdog_pkg::ST_LEAD:
                begin
                    if (rxd_prev && !rxd_sync[1])
                        win_count <= 13'h0000;
                    else if (kick_event)
                    begin
                        state <= wdog_pkg::ST_CLOSED;
                        win_count <= 13'h0000;
                    end
                    else if (tick && win_count >= 13'(`LEAD_TICKS - 1))
                    begin
                        state <= wdog_pkg::ST_RESET;
                        win_count <= 13'h0000;
                    end
                    else if (tick)
                        win_count <= win_count + 13'h0001;
                end
                wdog_pkg::ST_CLOSED:
                begin
                    if (kick_event)
                    begin
                        state <= wdog_pkg::ST_RESET;
                        win_count <= 13'h0000;
                    end
                    else if (tick && win_count >= 13'(`CLOSED_TICKS - 1))
                    begin
                        state <= wdog_pkg::ST_OPEN;
                        win_count <= 13'h0000;
                    end
                    else if (tick)
                        win_count <= win_count + 13'h0001;
                end
                wdog_pkg::ST_OPEN:
                begin
                    if (kick_event)
                    begin
                        state <= wdog_pkg::ST_CLOSED;
                        win_count <= 13'h0000;
                    end
                    else if (tick && win_count >= 13'(`OPEN_TICKS - 1))
                    begin
                        state <= wdog_pkg::ST_RESET;
                        win_count <= 13'h0000;
                    end
                    else if (tick)
                        win_count <= win_count + 13'h0001;
                end
                default:
                begin
                    state <= wdog_pkg::ST_POR;
                    win_count <= 13'h0000;
                    reset_count <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign reset_drive = uv || state == wdog_pkg::ST_POR || state == wdog_pkg::ST_RESET;

    // Pin drive is open drain: drive low only, never high
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sys_reset_n_out <= 1'b0;
            sys_reset_n_oe <= 1'b1;
            wd_state <= 5'h01;
        end
        else
        begin
            sys_reset_n_out <= 1'b0;
            sys_reset_n_oe <= reset_drive;
            wd_state <= state;
        end
    end

    // Remember why the line went low; undervoltage outranks the watchdog
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            last_src <= wdog_pkg::SRC_UVOLT;
            uv_seen <= 1'b1;
        end
        else if (uv || state == wdog_pkg::ST_POR)
        begin
            last_src <= wdog_pkg::SRC_UVOLT;
            uv_seen <= 1'b1;
        end
        else if (state == wdog_pkg::ST_RESET)
        begin
            last_src <= wdog_pkg::SRC_WDOG;
            uv_seen <= 1'b0;
        end
        else if (!pin_sync[1] && !uv_seen && last_src == wdog_pkg::SRC_NONE)
            last_src <= wdog_pkg::SRC_WDOG;
    end

    // Fail-safe entry on any low reset line, including one pulled by others
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fail_safe <= 1'b1;
            source_valid <= 1'b1;
            source_code <= '{txd: 1'b1, rxd: 1'b0};
        end
        else
        begin
            if (reset_drive || !pin_sync[1])
                fail_safe <= 1'b1;
            else if (low_power)
                fail_safe <= 1'b0;
            source_valid <= last_src != wdog_pkg::SRC_NONE && fail_safe;
            source_code.txd <= 1'b1;
            source_code.rxd <= last_src == wdog_pkg::SRC_WDOG;
        end
    end
endmodule
`default_nettype wire
